// ---- hw/upsc_pkg.sv ----
// Shared constants, field layouts and carrier types of the protocol parameter block.
package upsc_pkg;

   // ==========================================================
   // Register byte offsets on the APB port.
   localparam logic [7:0] OFF_PARAM_TWO = 8'h00;
   localparam logic [7:0] OFF_PARAM_THREE = 8'h04;
   localparam logic [7:0] OFF_PARAM_THREE_HIGH = 8'h08;
   localparam logic [7:0] OFF_TX_CHECKSUM = 8'h0C;
   localparam logic [7:0] OFF_RX_CHECKSUM = 8'h10;
   localparam logic [7:0] OFF_SMARTCARD_CONFIG = 8'h14;
   localparam logic [7:0] OFF_SMARTCARD_IRQ = 8'h18;
   localparam logic [7:0] OFF_WAKE_BAUD_IRQ = 8'h1C;
   localparam logic [7:0] OFF_PROTOCOL_CTRL = 8'h20;

   // ==========================================================
   // Implemented bits of each register; all others read as zero.
   localparam logic [15:0] MASK_PARAM_TWO = 16'h01FF;
   localparam logic [15:0] MASK_PARAM_THREE = 16'hFFFF;
   localparam logic [15:0] MASK_PARAM_THREE_HIGH = 16'h00FF;
   localparam logic [15:0] MASK_CHECKSUM = 16'h00FF;
   localparam logic [15:0] MASK_SMARTCARD_CONFIG = 16'h003E;
   localparam logic [15:0] MASK_SMARTCARD_IRQ = 16'h3737;
   localparam logic [15:0] MASK_WAKE_BAUD_IRQ = 16'h00C4;
   localparam logic [15:0] MASK_PROTOCOL_CTRL = 16'h0077;
   localparam logic [15:0] RESET_VALUE = 16'h0000;

   // ==========================================================
   // Field positions.
   localparam int RPT_SEL_LSB = 4;
   localparam int INVERSE_POLARITY_SELECT_BIT = 3;
   localparam int T_ZERO_PULLDOWN_LENGTH_BIT = 2;
   localparam int CARD_PROTOCOL_SELECT_BIT = 1;
   localparam int RX_RPT_FLAG_BIT = 13;
   localparam int TX_RPT_FLAG_BIT = 12;
   localparam int BLOCK_FLAG_BIT = 10;
   localparam int WAIT_FLAG_BIT = 9;
   localparam int GUARD_FLAG_BIT = 8;
   localparam int SC_FLAG_TO_EN = 8;
   localparam int WAKE_FLAG_BIT = 7;
   localparam int BAUD_FLAG_BIT = 6;
   localparam int BAUD_IRQ_EN_BIT = 2;
   localparam int MODE_LSB = 0;
   localparam int CHK_INCLUDE_BIT = 4;
   localparam int WAKE_EN_BIT = 5;
   localparam int BAUD_EN_BIT = 6;

   // ==========================================================
   // Counts of events and ETU.
   localparam logic [2:0] RX_RECEPTION_LIMIT = 3'h5;
   localparam logic [1:0] PULLDOWN_LONG_ETU = 2'h2;
   localparam logic [1:0] PULLDOWN_SHORT_ETU = 2'h1;

   // ==========================================================
   // Modes and carrier types.
   typedef enum logic [2:0] {
      UPSC_MODE_ASYNC,
      UPSC_MODE_ASYNC_ADDR,
      UPSC_MODE_LIN_CMD,
      UPSC_MODE_LIN_RESP,
      UPSC_MODE_LIN_CMD_RESP,
      UPSC_MODE_SMART_CARD
   } upsc_mode_t;

   typedef struct packed {
      logic valid;
      logic is_pid;
      logic [7:0] data;
   } upsc_byte_ev_t;

   typedef struct packed {
      logic [7:0] resp_tx_count;
      logic [7:0] resp_rx_count;
      logic [7:0] match_addr;
      logic [7:0] match_mask;
   } upsc_lin_cfg_t;

   typedef struct packed {
      logic [1:0] retransmit_count_select;
      logic inverse_polarity_select;
      logic t_zero_pulldown_length;
      logic card_protocol_select;
   } upsc_sc_cfg_t;

   // Adds a byte into a sum and folds the carry back into bit 0.
   function automatic logic [7:0] upsc_sum_wrap(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

endpackage

// ---- hw/upsc_core.sv ----
// Protocol parameter, checksum and smart-card timing block with its APB register file.
//
// Notes on behaviour
// - LIN responder transmit: low byte of parameter two is the response byte count.
// - Address-detect receive: low byte of parameter two is the match address.
// - Smart card: nine-bit parameter two loads the block time counter, one ETU steps.
// - LIN responder receive: low byte of parameter three is the receive byte count.
// - Async receive: parameter three low bits select which address bits are compared.
// - Smart card: waiting time counter is parameter three high and low, 24 bits.
// - LIN transmit checksum: wrapped-carry sum of data, identifier only when enabled.
// - LIN receive checksum: wrapped-carry sum of data, identifier only when enabled.
// - LIN responder modes clear both checksums when a Break is seen.
// - Other modes add every byte into checksums only while the option is set.
// - Smart card: error byte is resent one to four times per select code.
// - T=0 error pull-down lasts two ETU when bit set, else one ETU.
// - Protocol select bit one means T=1, zero means T=0.
// - Receive-repeat flag sets when parity fails on the fifth reception.
// - Transmit-repeat flag sets on line error after the last allowed retransmit.
// - Block, waiting and guard flags set at counter zero; software may write them.
// - Each smart-card flag raises the interrupt only while its enable is set.
// - Wake enabled: falling receive line sets wake flag and event interrupt.
// - Baud detect enabled: final falling edge sets the baud-done flag.
// - Baud-done flag raises the event interrupt only when its enable is set.
// - Smart card: nine-bit parameter one loads the guard time counter.
module upsc_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_line,
   input wire logic etu_tick,
   input wire upsc_pkg::upsc_byte_ev_t tx_ev,
   input wire upsc_pkg::upsc_byte_ev_t rx_ev,
   input wire logic break_detected,
   input wire logic baud_detect_sequence,
   input wire logic rx_addr_valid,
   input wire logic [7:0] rx_addr,
   input wire logic [8:0] param_one_field,
   input wire logic guard_start,
   input wire logic block_start,
   input wire logic wait_start,
   input wire logic sc_rx_parity_err,
   input wire logic sc_rx_char_ok,
   input wire logic sc_tx_line_err,
   input wire logic sc_tx_char_ok,
   input wire logic t0_err_start,
   output upsc_pkg::upsc_mode_t mode,
   output upsc_pkg::upsc_lin_cfg_t lin_cfg,
   output upsc_pkg::upsc_sc_cfg_t sc_cfg,
   output logic addr_match,
   output upsc_pkg::upsc_byte_ev_t card_rx_byte,
   output logic retransmit_req,
   output logic line_pulldown,
   output logic sc_irq,
   output logic event_irq
);
   import upsc_pkg::*;

   // ==========================================================
   // Register storage.
   logic [15:0] param_two;
   logic [15:0] param_three;
   logic [15:0] param_three_high;
   logic [7:0] tx_sum_value;
   logic [7:0] rx_sum_value;
   logic [15:0] smartcard_config;
   logic [15:0] smartcard_irq;
   logic [15:0] wake_baud_irq;
   logic [15:0] protocol_ctrl;

   // ==========================================================
   // APB slave: one wait state, read data and error captured in a flop.
   wire access = psel && penable && !pready;
   wire wr_en = psel && penable && pready && pwrite;
   wire [15:0] wdata = pwdata[15:0];
   wire wr_p2 = wr_en && (paddr == OFF_PARAM_TWO);
   wire wr_p3 = wr_en && (paddr == OFF_PARAM_THREE);
   wire wr_p3h = wr_en && (paddr == OFF_PARAM_THREE_HIGH);
   wire wr_txc = wr_en && (paddr == OFF_TX_CHECKSUM);
   wire wr_rxc = wr_en && (paddr == OFF_RX_CHECKSUM);
   wire wr_scc = wr_en && (paddr == OFF_SMARTCARD_CONFIG);
   wire wr_sci = wr_en && (paddr == OFF_SMARTCARD_IRQ);
   wire wr_wbi = wr_en && (paddr == OFF_WAKE_BAUD_IRQ);
   wire wr_ctl = wr_en && (paddr == OFF_PROTOCOL_CTRL);

   // Read multiplexer; an unmapped address reads zero and answers with an error.
   logic [15:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (paddr)
         OFF_PARAM_TWO: rd_mux = param_two;
         OFF_PARAM_THREE: rd_mux = param_three;
         OFF_PARAM_THREE_HIGH: rd_mux = param_three_high;
         OFF_TX_CHECKSUM: rd_mux = {8'h00, tx_sum_value};
         OFF_RX_CHECKSUM: rd_mux = {8'h00, rx_sum_value};
         OFF_SMARTCARD_CONFIG: rd_mux = smartcard_config;
         OFF_SMARTCARD_IRQ: rd_mux = smartcard_irq;
         OFF_WAKE_BAUD_IRQ: rd_mux = wake_baud_irq;
         OFF_PROTOCOL_CTRL: rd_mux = protocol_ctrl;
         default: begin
            rd_mux = RESET_VALUE;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Bus answer flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         prdata <= (access && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
         pslverr <= access && !rd_hit;
      end
   end

   // ==========================================================
   // Decoded controls.
   wire [2:0] mode_code = protocol_ctrl[MODE_LSB +: 3];
   wire upsc_mode_t mode_dec = (mode_code > 3'h5) ? UPSC_MODE_ASYNC : upsc_mode_t'(mode_code);
   wire sc_mode = (mode_dec == UPSC_MODE_SMART_CARD);
   wire lin_mode = (mode_dec == UPSC_MODE_LIN_CMD) || (mode_dec == UPSC_MODE_LIN_RESP) ||
                   (mode_dec == UPSC_MODE_LIN_CMD_RESP);
   wire lin_resp = (mode_dec == UPSC_MODE_LIN_RESP) || (mode_dec == UPSC_MODE_LIN_CMD_RESP);
   wire chk_include = protocol_ctrl[CHK_INCLUDE_BIT];
   wire wake_en = protocol_ctrl[WAKE_EN_BIT];
   wire baud_detect_enable = protocol_ctrl[BAUD_EN_BIT];
   wire [1:0] rpt_sel = smartcard_config[RPT_SEL_LSB +: 2];

   // Parameter registers and mode control.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         param_two <= RESET_VALUE;
         param_three <= RESET_VALUE;
         param_three_high <= RESET_VALUE;
         smartcard_config <= RESET_VALUE;
         protocol_ctrl <= RESET_VALUE;
      end else begin
         if (wr_p2) param_two <= wdata & MASK_PARAM_TWO;
         if (wr_p3) param_three <= wdata & MASK_PARAM_THREE;
         if (wr_p3h) param_three_high <= wdata & MASK_PARAM_THREE_HIGH;
         if (wr_scc) smartcard_config <= wdata & MASK_SMARTCARD_CONFIG;
         if (wr_ctl) protocol_ctrl <= wdata & MASK_PROTOCOL_CTRL;
      end
   end

   // ==========================================================
   // Checksums: break clear first, then hardware add over any written value.
   wire tx_add = tx_ev.valid && (lin_mode ? (chk_include || !tx_ev.is_pid) : chk_include);
   wire rx_add = rx_ev.valid && (lin_mode ? (chk_include || !rx_ev.is_pid) : chk_include);
   wire [7:0] tx_base = wr_txc ? wdata[7:0] : tx_sum_value;
   wire [7:0] rx_base = wr_rxc ? wdata[7:0] : rx_sum_value;
   wire [7:0] next_tx_sum = (lin_resp && break_detected) ? 8'h00 :
                            tx_add ? upsc_sum_wrap(tx_base, tx_ev.data) : tx_base;
   wire [7:0] next_rx_sum = (lin_resp && break_detected) ? 8'h00 :
                            rx_add ? upsc_sum_wrap(rx_base, rx_ev.data) : rx_base;

   // Checksum flops; outside LIN the option alone gates the add.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sum_value <= 8'h00;
         rx_sum_value <= 8'h00;
      end else begin
         tx_sum_value <= next_tx_sum;
         rx_sum_value <= next_rx_sum;
      end
   end

   // ==========================================================
   // Smart-card time counters: 0 guard, 1 block, 2 waiting.
   logic [23:0] tcnt [3];
   logic [2:0] trun;
   wire [2:0] tstart = {wait_start, block_start, guard_start} & {3{sc_mode}};
   wire [23:0] tload [3];
   assign tload[0] = {15'h0000, param_one_field};
   assign tload[1] = {15'h0000, param_two[8:0]};
   assign tload[2] = {param_three_high[7:0], param_three};
   wire [2:0] thit;
   for (genvar i = 0; i < 3; i++) begin : g_hit
      assign thit[i] = trun[i] && etu_tick && (tcnt[i] <= 24'h00_0001) && !tstart[i];
   end

   // Load on start, step once per ETU, stop on reaching zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trun <= 3'h0;
         for (int i = 0; i < 3; i++) tcnt[i] <= 24'h00_0000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (tstart[i]) begin
               tcnt[i] <= tload[i];
               trun[i] <= 1'b1;
            end else if (trun[i] && etu_tick) begin
               tcnt[i] <= (tcnt[i] == 24'h00_0000) ? tcnt[i] : tcnt[i] - 24'h00_0001;
               trun[i] <= !thit[i];
            end
         end
      end
   end

   // ==========================================================
   // Repeat counting for receive parity errors and transmit line errors.
   logic [2:0] rx_rpt_cnt;
   logic [2:0] tx_rpt_cnt;
   wire [2:0] rpt_limit = {1'b0, rpt_sel} + 3'h1;
   wire rx_rpt_hit = sc_mode && sc_rx_parity_err && (rx_rpt_cnt + 3'h1 == RX_RECEPTION_LIMIT);
   wire tx_rpt_hit = sc_mode && sc_tx_line_err && (tx_rpt_cnt == rpt_limit);
   wire tx_resend = sc_mode && sc_tx_line_err && (tx_rpt_cnt < rpt_limit);

   // Count failed receptions and retransmits; success or exhaustion restarts the count.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_rpt_cnt <= 3'h0;
         tx_rpt_cnt <= 3'h0;
         retransmit_req <= 1'b0;
      end else begin
         if (sc_rx_char_ok || rx_rpt_hit) rx_rpt_cnt <= 3'h0;
         else if (sc_mode && sc_rx_parity_err) rx_rpt_cnt <= rx_rpt_cnt + 3'h1;
         if (sc_tx_char_ok || tx_rpt_hit) tx_rpt_cnt <= 3'h0;
         else if (tx_resend) tx_rpt_cnt <= tx_rpt_cnt + 3'h1;
         retransmit_req <= tx_resend;
      end
   end

   // ==========================================================
   // Smart-card flags and enables; hardware set wins over a software clear.
   logic [15:0] sc_set;
   always_comb begin
      sc_set = 16'h0000;
      sc_set[RX_RPT_FLAG_BIT] = rx_rpt_hit;
      sc_set[TX_RPT_FLAG_BIT] = tx_rpt_hit;
      sc_set[GUARD_FLAG_BIT] = thit[0];
      sc_set[BLOCK_FLAG_BIT] = thit[1];
      sc_set[WAIT_FLAG_BIT] = thit[2];
   end
   wire [15:0] sc_base = wr_sci ? (wdata & MASK_SMARTCARD_IRQ) : smartcard_irq;

   // Wake and baud flags from the synchronised receive line and the detector.
   logic [2:0] rx_sync;
   wire rx_fall = (rx_sync[2:1] == 2'b10);
   logic [15:0] wb_set;
   always_comb begin
      wb_set = 16'h0000;
      wb_set[WAKE_FLAG_BIT] = wake_en && rx_fall;
      wb_set[BAUD_FLAG_BIT] = baud_detect_enable && baud_detect_sequence;
   end
   wire [15:0] wb_base = wr_wbi ? (wdata & MASK_WAKE_BAUD_IRQ) : wake_baud_irq;
   wire [15:0] sc_pend = smartcard_irq & {smartcard_irq[7:0], 8'h00};

   // Flag registers, interrupt outputs and receive line synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smartcard_irq <= RESET_VALUE;
         wake_baud_irq <= RESET_VALUE;
         rx_sync <= 3'b111;
         sc_irq <= 1'b0;
         event_irq <= 1'b0;
      end else begin
         smartcard_irq <= sc_base | sc_set;
         wake_baud_irq <= wb_base | wb_set;
         rx_sync <= {rx_sync[1:0], rx_line};
         sc_irq <= |sc_pend;
         event_irq <= wake_baud_irq[WAKE_FLAG_BIT] ||
                      (wake_baud_irq[BAUD_FLAG_BIT] && wake_baud_irq[BAUD_IRQ_EN_BIT]);
      end
   end

   // ==========================================================
   // T=0 error pull-down, counted in ETU ticks.
   logic [1:0] pd_left;
   wire [1:0] pd_len = smartcard_config[T_ZERO_PULLDOWN_LENGTH_BIT] ? PULLDOWN_LONG_ETU : PULLDOWN_SHORT_ETU;
   wire pd_start = sc_mode && !smartcard_config[CARD_PROTOCOL_SELECT_BIT] && t0_err_start;

   // Hold the line low from the start until the chosen number of ETU has passed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_left <= 2'h0;
         line_pulldown <= 1'b0;
      end else if (pd_start) begin
         pd_left <= pd_len;
         line_pulldown <= 1'b1;
      end else if (line_pulldown && etu_tick) begin
         pd_left <= pd_left - 2'h1;
         line_pulldown <= (pd_left != 2'h1);
      end
   end

   // ==========================================================
   // Card character convention: inverse means complemented and bit-reversed.
   wire [7:0] rx_rev = {<<{rx_ev.data}};
   wire use_inverse = sc_mode && smartcard_config[INVERSE_POLARITY_SELECT_BIT];
   wire [7:0] masked_addr_diff = (rx_addr ^ param_two[7:0]) & param_three[7:0];

   // Configuration outputs, address match and converted card character.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= UPSC_MODE_ASYNC;
         lin_cfg <= '0;
         sc_cfg <= '0;
         addr_match <= 1'b0;
         card_rx_byte <= '0;
      end else begin
         mode <= mode_dec;
         lin_cfg.resp_tx_count <= param_two[7:0];
         lin_cfg.match_addr <= param_two[7:0];
         lin_cfg.resp_rx_count <= param_three[7:0];
         lin_cfg.match_mask <= param_three[7:0];
         sc_cfg <= smartcard_config[5:1];
         addr_match <= rx_addr_valid && (masked_addr_diff == 8'h00);
         card_rx_byte.valid <= rx_ev.valid;
         card_rx_byte.is_pid <= rx_ev.is_pid;
         card_rx_byte.data <= use_inverse ? ~rx_rev : rx_ev.data;
      end
   end

   // ==========================================================
   // Checks.
   sequence s_t0_start;
      pd_start;
   endsequence

   a_pready_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      access |=> pready ##1 !pready) else $error("APB answer timing wrong");
   a_wake_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      wake_en && rx_fall |=> wake_baud_irq[WAKE_FLAG_BIT] ##1 event_irq)
      else $error("Wake flag or event interrupt missing");
   a_baud_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      baud_detect_enable && baud_detect_sequence |=> wake_baud_irq[BAUD_FLAG_BIT])
      else $error("Baud-done flag not set");
   a_baud_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !wake_baud_irq[WAKE_FLAG_BIT] && !wake_baud_irq[BAUD_IRQ_EN_BIT] |=> !event_irq)
      else $error("Event interrupt without enable");
   a_break_clears_sum: assert property (@(posedge pclk) disable iff (!presetn)
      lin_resp && break_detected |=> tx_sum_value == 8'h00 && rx_sum_value == 8'h00)
      else $error("Break did not clear checksums");
   a_sum_hold_off: assert property (@(posedge pclk) disable iff (!presetn)
      !lin_mode && !chk_include && !wr_txc |=> $stable(tx_sum_value))
      else $error("Transmit checksum changed with option clear");
   a_pulldown_len: assert property (@(posedge pclk) disable iff (!presetn)
      s_t0_start |=> line_pulldown && pd_left == $past(pd_len))
      else $error("Pull-down length wrong");
   a_tx_repeat_flag: assert property (@(posedge pclk) disable iff (!presetn)
      tx_rpt_hit |=> smartcard_irq[TX_RPT_FLAG_BIT] && !retransmit_req)
      else $error("Transmit repeat flag not set");
   a_rx_repeat_flag: assert property (@(posedge pclk) disable iff (!presetn)
      sc_mode && sc_rx_parity_err && rx_rpt_cnt == 3'h4 |=> smartcard_irq[RX_RPT_FLAG_BIT])
      else $error("Receive repeat flag not set");
   a_guard_flag_zero: assert property (@(posedge pclk) disable iff (!presetn)
      thit[0] |=> smartcard_irq[GUARD_FLAG_BIT] && !trun[0])
      else $error("Guard flag not set at zero");
   a_sc_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      sc_pend == 16'h0000 |=> !sc_irq)
      else $error("Smart-card interrupt without enabled flag");

endmodule

// ---- verification/upsc_far_model.sv ----
// Far-side peer model: card bit clock and receive line.
module upsc_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic fall_req,
   output logic etu_tick,
   output logic rx_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div;
   logic [3:0] low_cnt;
   // One bit clock pulse every four clocks; the line drops for a start bit on request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 2'h0;
         low_cnt <= 4'h0;
      end else begin
         div <= div + 2'h1;
         low_cnt <= fall_req ? 4'h8 : low_cnt - {3'h0, low_cnt != 4'h0};
      end
   end
   assign etu_tick = (div == 2'h3);
   // The line idles high whenever no low period is counting down.
   assign rx_line = (low_cnt == 4'h0);
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the protocol parameter block over APB.
module testbench import upsc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sc_irq, event_irq, retransmit_req;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, wv[9];
   logic [8:0] kv;
   logic [7:0] ra;
   logic am, lp;
   upsc_sc_cfg_t scc;
   logic [32:0] e;
   logic etu_tick, rx_line;
   upsc_byte_ev_t tx_ev, rx_ev, crb;
   upsc_lin_cfg_t lin_cfg;
   logic brk;
   logic [32:0] expq[$];
   int fails, n_tests, cyc, seed;
   localparam logic [7:0] OFFS[9] = '{OFF_PARAM_TWO, OFF_PARAM_THREE, OFF_PARAM_THREE_HIGH,
      OFF_TX_CHECKSUM, OFF_RX_CHECKSUM, OFF_SMARTCARD_CONFIG, OFF_SMARTCARD_IRQ,
      OFF_WAKE_BAUD_IRQ, OFF_PROTOCOL_CTRL};
   localparam logic [15:0] MSKS[9] = '{MASK_PARAM_TWO, MASK_PARAM_THREE, MASK_PARAM_THREE_HIGH,
      MASK_CHECKSUM, MASK_CHECKSUM, MASK_SMARTCARD_CONFIG, MASK_SMARTCARD_IRQ,
      MASK_WAKE_BAUD_IRQ, MASK_PROTOCOL_CTRL};
   upsc_core u_upsc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_line(rx_line), .etu_tick(etu_tick), .tx_ev(tx_ev), .rx_ev(rx_ev),
      .break_detected(brk), .baud_detect_sequence(kv[1]), .rx_addr_valid(kv[8]),
      .rx_addr(ra), .param_one_field(9'h000), .guard_start(kv[4]), .block_start(kv[0]),
      .wait_start(kv[5]), .sc_rx_parity_err(kv[6]), .sc_rx_char_ok(1'b0),
      .sc_tx_line_err(kv[3]), .sc_tx_char_ok(1'b0), .t0_err_start(kv[7]), .mode(),
      .lin_cfg(lin_cfg), .sc_cfg(scc), .addr_match(am), .card_rx_byte(crb), .line_pulldown(lp),
      .retransmit_req(retransmit_req), .sc_irq(sc_irq), .event_irq(event_irq));
   upsc_far_model u_upsc_far_model (.pclk(pclk), .presetn(presetn), .fall_req(kv[2]),
      .etu_tick(etu_tick), .rx_line(rx_line));
   // Wrapped-carry byte sum used for expected checksums.
   function automatic logic [7:0] fold(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction
   task automatic chk(input logic [32:0] g, input logic [32:0] x);
      n_tests++;
      if (g !== x) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // APB transfer: setup, access, hold until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] v, input logic err);
      expq.push_back({err, 16'h0000, v});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic ev(input upsc_byte_ev_t t, input upsc_byte_ev_t r, input logic b);
      @(posedge pclk);
      tx_ev <= t;
      rx_ev <= r;
      brk <= b;
      @(posedge pclk);
      tx_ev <= '0;
      rx_ev <= '0;
      brk <= 1'b0;
   endtask
   task automatic kick(input int k);
      @(posedge pclk);
      kv[k] <= 1'b1;
      @(posedge pclk);
      kv[k] <= 1'b0;
   endtask
   // Read answers are compared against the oldest noted expectation.
   always @(posedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         e = expq.pop_front();
         chk({pslverr, prdata}, e);
      end
   end
   // Hang guard.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Main sequence.
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, kv, ra, brk, tx_ev, rx_ev} = '0;
      seed = 32'h91d2;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++) rd(OFFS[i], RESET_VALUE, 1'b0);
      rd(8'h24, 16'h0000, 1'b1);
      for (int i = 0; i < 9; i++) begin
         wv[i] = $random(seed);
         apb(1'b1, OFFS[i], wv[i]);
         rd(OFFS[i], wv[i][15:0] & MSKS[i], 1'b0);
      end
      chk(lin_cfg, {wv[0][7:0], wv[1][7:0], wv[0][7:0], wv[1][7:0]});
      chk(scc, wv[5][5:1]);
      ra <= wv[0][7:0] ^ ~wv[1][7:0];
      kick(8);
      @(negedge pclk);
      chk(am, 1);
      @(posedge pclk);
      ra <= wv[0][7:0] ^ wv[1][7:0];
      kick(8);
      @(negedge pclk);
      chk(am, wv[1][7:0] == 8'h00);
      for (int i = 0; i < 9; i++) apb(1'b1, OFFS[i], 32'h0000_0000);
      $display("test registers done");
      apb(1'b1, OFF_PROTOCOL_CTRL, 32'h0000_0013);
      apb(1'b1, OFF_TX_CHECKSUM, 32'h0000_0020);
      ev('{1'b1, 1'b0, 8'hF0}, '0, 1'b0);
      ev('{1'b1, 1'b1, 8'h01}, '{1'b1, 1'b0, 8'hFF}, 1'b0);
      rd(OFF_TX_CHECKSUM, {8'h00, fold(fold(8'h20, 8'hF0), 8'h01)}, 1'b0);
      apb(1'b1, OFF_PROTOCOL_CTRL, 32'h0000_0003);
      ev('{1'b1, 1'b1, 8'h05}, '{1'b1, 1'b0, 8'h01}, 1'b0);
      rd(OFF_TX_CHECKSUM, 16'h0012, 1'b0);
      rd(OFF_RX_CHECKSUM, {8'h00, fold(8'hFF, 8'h01)}, 1'b0);
      ev('0, '0, 1'b1);
      rd(OFF_TX_CHECKSUM, 16'h0000, 1'b0);
      apb(1'b1, OFF_PROTOCOL_CTRL, 32'h0000_0000);
      ev('{1'b1, 1'b0, 8'h33}, '0, 1'b0);
      rd(OFF_TX_CHECKSUM, 16'h0000, 1'b0);
      apb(1'b1, OFF_PROTOCOL_CTRL, 32'h0000_0010);
      ev('{1'b1, 1'b0, 8'h33}, '{1'b1, 1'b0, 8'h44}, 1'b0);
      rd(OFF_RX_CHECKSUM, 16'h0044, 1'b0);
      $display("test checksum done");
      apb(1'b1, OFF_PROTOCOL_CTRL, 32'h0000_0005);
      apb(1'b1, OFF_PARAM_TWO, 32'h0000_0003);
      apb(1'b1, OFF_SMARTCARD_IRQ, 32'h0000_0014);
      kick(0);
      repeat (40) if (sc_irq !== 1'b1) @(posedge pclk);
      chk(sc_irq, 1);
      rd(OFF_SMARTCARD_IRQ, 16'h0414, 1'b0);
      apb(1'b1, OFF_SMARTCARD_IRQ, 32'h0000_0010);
      kick(3);
      @(negedge pclk);
      chk(retransmit_req, 1);
      kick(3);
      kick(4);
      kick(5);
      repeat (5) kick(6);
      repeat (8) @(posedge pclk);
      rd(OFF_SMARTCARD_IRQ, 16'h3310, 1'b0);
      apb(1'b1, OFF_SMARTCARD_CONFIG, 32'h0000_000C);
      ev('0, '{1'b1, 1'b0, 8'h01}, 1'b0);
      @(negedge pclk);
      chk(crb, {2'b10, 8'h7F});
      kick(7);
      @(negedge pclk);
      chk(lp, 1);
      @(posedge pclk iff etu_tick);
      @(negedge pclk);
      chk(lp, 1);
      @(posedge pclk iff etu_tick);
      @(negedge pclk);
      chk(lp, 0);
      apb(1'b1, OFF_SMARTCARD_CONFIG, 32'h0000_0002);
      kick(7);
      @(negedge pclk);
      chk(lp, 0);
      $display("test smart card done");
      apb(1'b1, OFF_PROTOCOL_CTRL, 32'h0000_0060);
      kick(2);
      repeat (20) if (event_irq !== 1'b1) @(posedge pclk);
      chk(event_irq, 1);
      rd(OFF_WAKE_BAUD_IRQ, 16'h0080, 1'b0);
      apb(1'b1, OFF_WAKE_BAUD_IRQ, 32'h0000_0000);
      kick(1);
      repeat (3) @(posedge pclk);
      chk(event_irq, 0);
      rd(OFF_WAKE_BAUD_IRQ, 16'h0040, 1'b0);
      apb(1'b1, OFF_WAKE_BAUD_IRQ, 32'h0000_0044);
      repeat (3) @(posedge pclk);
      chk(event_irq, 1);
      $display("test events done");
      end_sim();
   end
endmodule
